/* verification/dual_up_timer_counter_bench.sv */
// self-checking bench for the dual up timer counter
`timescale 1ns/1ps
`include "dual_timer_cfg.svh"
module dual_up_timer_counter_bench
    import dual_timer_pkg::*;
;
    logic  clk = 0, sysRst = 1, cyc = 0, stb = 0, we = 0, sel = 0;
    logic  cpuTk = 0, oscTk = 0, slowTk = 0, pin0 = 0, pin1 = 0, ack0 = 0, ack1 = 0;
    logic  ack, irq0, irq1, wake, stopped;
    byte_t adr = 0, wdat = 0, rdat, q;
    int    n_fail = 0, checked = 0, r;
    // address, written value, value read back
    byte_t rows [9][3] = '{'{`ADR_T0LO, 8'h5a, 8'h5a}, '{`ADR_T0HI, 8'ha5, 8'ha5},
        '{`ADR_T1LO, 8'h3c, 8'h3c}, '{`ADR_T1HI, 8'hc3, 8'hc3}, '{`ADR_TCTRL, 8'h0f, 8'h00},
        '{`ADR_TMODE, 8'h33, 8'h33}, '{`ADR_PRESC, 8'hff, 8'hf7},
        '{`ADR_IENMAIN, 8'h8a, 8'h8a}, '{8'h90, 8'h55, 8'h00}};

    always #2 clk = ~clk;

    dual_up_timer_counter dut (.clk(clk), .sys_rst(sysRst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
        .wb_ack_o(ack), .cpuTick(cpuTk), .oscTick(oscTk), .slowTick(slowTk),
        .ext_irq0_pin(pin0), .ext_irq1_pin(pin1), .tmr0IrqAck(ack0), .tmr1IrqAck(ack1),
        .tmr0IrqReq(irq0), .tmr1IrqReq(irq1), .stopWakeReq(wake), .stopMode(stopped));

    task check(input string nm, input byte_t seen, input byte_t exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task wrap_up;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up

    // one classic cycle, held until ack is sampled high
    task bus(input byte_t a, input byte_t d, input logic w);
        int i;
        @(posedge clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (ack !== 1'b1 && i < 50);
        q = rdat;
        cyc <= 0;
        stb <= 0;
        if (i >= 50) begin
            n_fail++;
            wrap_up();
        end
    endtask : bus

    task rd(input byte_t a, input byte_t e);
        bus(a, 8'h00, 1'b0);
        check($sformatf("reg %h", a), q, e);
    endtask : rd

    // k selects cpu, osc or slow tick; pulses spaced so none merge
    task tick(input int k, input int n);
        repeat (n) begin
            @(posedge clk);
            {slowTk, oscTk, cpuTk} <= 3'b001 << k;
            @(posedge clk);
            {slowTk, oscTk, cpuTk} <= 3'b000;
        end
        repeat (4) @(posedge clk);
    endtask : tick

    task wait_hi(input int k);
        logic [2:0] v;
        for (int i = 0; i < 400; i++) begin
            @(posedge clk);
            v = {wake, irq1, irq0};
            if (v[k] === 1'b1) return;
        end
        n_fail++;
        wrap_up();
    endtask : wait_hi

    initial begin
        repeat (4) @(posedge clk);
        sysRst <= 0;
        for (r = 0; r < 9; r++) begin
            rd(rows[r][0], 8'h00);
            bus(rows[r][0], rows[r][1], 1'b1);
            rd(rows[r][0], rows[r][2]);
        end
        $display("register table done");
        // timer 0, 16 bit, cpu over twelve
        bus(`ADR_TMODE, 8'h01, 1);
        bus(`ADR_PRESC, 8'h00, 1);
        bus(`ADR_IENMAIN, 8'h82, 1);
        bus(`ADR_T0LO, 8'hfe, 1);
        bus(`ADR_T0HI, 8'hff, 1);
        bus(`ADR_TCTRL, 8'h10, 1);
        tick(0, 23);
        rd(`ADR_T0LO, 8'hff);
        check("irq0", {7'h0, irq0}, 8'h00);
        tick(0, 1);
        wait_hi(0);
        rd(`ADR_T0HI, 8'h00);
        ack0 <= 1;
        @(posedge clk) ack0 <= 0;
        @(posedge clk);
        check("irq0", {7'h0, irq0}, 8'h00);
        $display("timer 0 wrap done");
        // timer 1 reload from osc, no division
        bus(`ADR_TMODE, 8'h60, 1);
        bus(`ADR_PRESC, 8'h07, 1);
        bus(`ADR_IENMAIN, 8'h88, 1);
        bus(`ADR_T1HI, 8'h80, 1);
        bus(`ADR_T1LO, 8'hfe, 1);
        bus(`ADR_TCTRL, 8'h40, 1);
        tick(1, 2);
        wait_hi(1);
        rd(`ADR_T1LO, 8'h80);
        bus(`ADR_TCTRL, 8'h40, 1);
        check("irq1", {7'h0, irq1}, 8'h00);
        // gated by pin 1, then stopped by run bit
        bus(`ADR_TMODE, 8'hd0, 1);
        bus(`ADR_T1LO, 8'h10, 1);
        tick(1, 3);
        rd(`ADR_T1LO, 8'h10);
        pin1 <= 1;
        // two synchroniser flops before the gate sees the pin
        repeat (2) @(posedge clk);
        tick(1, 3);
        rd(`ADR_T1LO, 8'h13);
        bus(`ADR_TCTRL, 8'h00, 1);
        tick(1, 2);
        rd(`ADR_T1LO, 8'h13);
        $display("timer 1 reload and gate done");
        // split: high byte of timer 0 runs on run1 and flag1
        bus(`ADR_TMODE, 8'h03, 1);
        bus(`ADR_T0HI, 8'hff, 1);
        bus(`ADR_TCTRL, 8'h40, 1);
        tick(0, 12);
        wait_hi(1);
        rd(`ADR_T0HI, 8'h00);
        rd(`ADR_T1LO, 8'h14);
        $display("split mode done");
        // slow source over 128, kept alive in stop, wakes on wrap
        // mid-run reset also clears the prescaler phase left by osc ticks
        @(posedge clk) sysRst <= 1;
        @(posedge clk) sysRst <= 0;
        rd(`ADR_T0LO, 8'h00);
        bus(`ADR_TMODE, 8'h05, 1);
        bus(`ADR_PRESC, 8'h80, 1);
        bus(`ADR_T0LO, 8'hff, 1);
        bus(`ADR_T0HI, 8'hff, 1);
        bus(`ADR_IENMAIN, 8'h82, 1);
        bus(`ADR_CLKCTL, 8'h03, 1);
        bus(`ADR_TCTRL, 8'h10, 1);
        check("stop", {7'h0, stopped}, 8'h01);
        tick(2, 127);
        rd(`ADR_T0LO, 8'hff);
        // last pulse by hand: the wake stands for one cycle only
        @(posedge clk) slowTk <= 1;
        @(posedge clk) slowTk <= 0;
        wait_hi(2);
        rd(`ADR_T0LO, 8'h00);
        check("stop", {7'h0, stopped}, 8'h00);
        $display("stop wake done");
        @(posedge clk) sysRst <= 1;
        @(posedge clk) sysRst <= 0;
        rd(`ADR_TCTRL, 8'h00);
        $display("reset done");
        wrap_up();
    end
endmodule : dual_up_timer_counter_bench

/* verification/dual_up_timer_counter_props.sv */
// bus handshake and interrupt level checker for the dual timer
`timescale 1ns/1ps
module dual_up_timer_counter_chk (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic [7:0] wb_dat_o,
    input wire logic       wb_ack_o,
    input wire logic       tmr0IrqAck,
    input wire logic       tmr1IrqAck,
    input wire logic       tmr0IrqReq,
    input wire logic       tmr1IrqReq,
    input wire logic       stopWakeReq,
    input wire logic       stopMode
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // slave answers every taken request exactly one cycle later, once
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    chk_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i) && $past(wb_cyc_i))
        else $error("ack without request");
    // reset must clear outputs even while reset is held
    chk_reset_clear: assert property (disable iff (1'b0)
        sys_rst |=> !wb_ack_o && !tmr0IrqReq && !tmr1IrqReq && wb_dat_o == 8'h00)
        else $error("outputs not cleared by reset");
    // read data must not drift between reads
    chk_dat_hold: assert property (!wb_ack_o && !$past(sys_rst) |-> $stable(wb_dat_o))
        else $error("read data changed without ack");
    // a flag only drops on service, a bus write or reset
    chk_irq0_drop: assert property ($fell(tmr0IrqReq)
        |-> $past(tmr0IrqAck) || $past(wb_cyc_i) || $past(sys_rst))
        else $error("timer 0 request dropped without cause");
    chk_irq1_drop: assert property ($fell(tmr1IrqReq)
        |-> $past(tmr1IrqAck) || $past(wb_cyc_i) || $past(sys_rst))
        else $error("timer 1 request dropped without cause");
    chk_wake_cause: assert property (stopWakeReq |-> stopMode && tmr0IrqReq)
        else $error("wake without stop and timer 0 request");
endmodule : dual_up_timer_counter_chk

bind dual_up_timer_counter dual_up_timer_counter_chk chk (.clk(clk), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tmr0IrqAck(tmr0IrqAck), .tmr1IrqAck(tmr1IrqAck), .tmr0IrqReq(tmr0IrqReq),
    .tmr1IrqReq(tmr1IrqReq), .stopWakeReq(stopWakeReq), .stopMode(stopMode));

/* verilog/dual_timer_cfg.svh */
// register offsets, field positions and timing counts for the dual timer
`ifndef DUAL_TIMER_CFG_SVH
`define DUAL_TIMER_CFG_SVH
`define ADR_TCTRL     8'h88
`define ADR_TMODE     8'h89
`define ADR_T0LO      8'h8a
`define ADR_T1LO      8'h8b
`define ADR_T0HI      8'h8c
`define ADR_T1HI      8'h8d
`define ADR_IENMAIN   8'ha8
`define ADR_PRESC     8'he7
`define ADR_CLKCTL    8'hf0
`define ADR_STATUS    8'hf1
`define BIT_T1FLAG    7
`define BIT_T1RUN     6
`define BIT_T0FLAG    5
`define BIT_T0RUN     4
`define BIT_T1IE      3
`define BIT_T0IE      1
`define BIT_GIE       7
`define BIT_T0SLOW    7
`define BIT_TMR1_PIN_GATE    7
`define BIT_T1CSEL    6
`define BIT_TMR0_PIN_GATE    3
`define BIT_T0CSEL    2
`define BIT_STOPREQ   1
`define BIT_STOP_WAKE_ENABLE      0
`define TCTRL_MASK    8'hf0
`define PRESC_MASK    8'hf7
`define CPU_DIV       4'd12
`define CPU_DIV_LAST  4'd11
`define LO13_LIMIT    8'h1f
`define RST_BYTE      8'h00
`endif

/* verilog/dual_timer_pkg.sv */
// types shared by the dual timer
package dual_timer_pkg;
    typedef enum logic [1:0] {
        MODE_13BIT  = 2'b00,
        MODE_16BIT  = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT  = 2'b11
    } tmr_mode_t;
    typedef logic [7:0] byte_t;
endpackage : dual_timer_pkg

/* verilog/dual_up_timer_counter.sv */
// two up-counting timers with prescalers, pin gating and a wishbone register slave
// Functional notes
// - timer 1 mode: 00 13-bit, 01 16-bit, 10 8-bit reload, 11 reserved
// - timer 0 mode: 00 13-bit, 01 16-bit, 10 reload, 11 split bytes
// - timer 0 ticks at fcpu/12, or external source over prescaler when selected
// - timer 0 external source is fosc, or flosc when bit 7 set
// - 3-bit prescaler: 000 divides by 128, halving per step, 111 by one
// - timer 1 ticks at fcpu/12 or fosc over its prescaler, no slow source
// - timer 1 clock select picks only the fcpu or fosc source
// - gate bit lets ext interrupt pin 0/1 pause timer 0/1
// - 13-bit mode ignores low byte top bits, flags on 0xff1f to zero
// - 16-bit mode counts both bytes, flags on 0xffff to zero
// - reload mode counts low byte, flags and reloads from high byte
// - split mode: low byte uses selected clock, high byte fcpu/12
// - split: low byte under run0 flag0, high byte under run1 flag1
// - split mode: timer 1 keeps counting but never flags
// - split mode gates only the low byte of timer 0
// - overflow sets flag; cleared on interrupt service or firmware write
// - enabled flag goes to interrupt controller, else stays for polling
// - slow-clocked timer 0 with stop-wake keeps counting in stop, wakes system if its interrupt is enabled
// - software reads and writes all count bytes, reset to zero
`timescale 1ns/1ps
`include "dual_timer_cfg.svh"
module dual_up_timer_counter
    import dual_timer_pkg::*;
#(
    parameter int PRESC_BITS = 3
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [7:0]  wb_dat_i,
    input  wire logic        wb_sel_i,
    output logic [7:0]       wb_dat_o,
    output logic             wb_ack_o,

    // rate enables from the clock unit, same domain, not synchronised
    input  wire logic        cpuTick,
    input  wire logic        oscTick,
    input  wire logic        slowTick,

    // gate pins, asynchronous to clk
    input  wire logic        ext_irq0_pin,
    input  wire logic        ext_irq1_pin,

    // interrupt controller side
    input  wire logic        tmr0IrqAck,
    input  wire logic        tmr1IrqAck,
    output logic             tmr0IrqReq,
    output logic             tmr1IrqReq,

    // power control side
    output logic             stopWakeReq,
    output logic             stopMode
);
    // the select decode and 7-bit divider only serve a 3-bit field
    if (PRESC_BITS != 3) begin : g_presc_check
        $error("prescaler field must be 3 bits");
    end

    // control registers
    logic [7:0] tctrl_q, tctrl_d, tmode_q, tmode_d, presc_q, presc_d;
    logic [7:0] ien_q, ien_d, clkctl_q, clkctl_d;
    byte_t      t0lo_q, t0lo_d, t0hi_q, t0hi_d, t1lo_q, t1lo_d, t1hi_q, t1hi_d;
    logic [7:0] rdat_q, rdat_d;
    logic       ack_q, ack_d;
    // prescaler state
    logic [3:0] cpuDiv_q, cpuDiv_d;
    logic [6:0] div0_q, div0_d, div1_q, div1_d;
    // pin synchronisers
    logic [1:0] pin0Sync_q, pin1Sync_q;

    // decoded modes and per-cycle count enables
    tmr_mode_t  mode0, mode1;
    logic       cpu12, src0, src1, ext0, tick0, tick1, tickHi;
    logic       gate0, gate1, pin0, pin1, stopped;
    // bus strobes and run bits
    logic       wr, rd, run0, run1;
    // one-cycle wrap events, they set the flags
    logic       ov0, ov1, ovHi;

    // true when a 7-bit prescale counter reaches the last count of the selected divisor
    function automatic logic prescDone(input logic [6:0] cnt, input logic [2:0] sel);
        logic [6:0] lim;
        lim = 7'h7f >> sel;
        prescDone = (cnt >= lim);
    endfunction : prescDone

    // next low/high pair for one count step in the given mode
    function automatic logic [16:0] stepCount(input tmr_mode_t m, input byte_t lo,
                                              input byte_t hi);
        logic [15:0] v;
        v = 16'h0000;
        stepCount = 17'h00000;
        case (m)
            // low five bits carry into the high byte
            MODE_13BIT: begin
                if (lo[4:0] == `LO13_LIMIT) begin
                    v = {hi + 8'h01, 3'b000, 5'h00};
                    stepCount = {(hi == 8'hff), v[15:8], lo[7:5], 5'h00};
                end else begin
                    stepCount = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
                end
            end
            // full carry lands in bit 16
            MODE_16BIT: begin
                stepCount = {1'b0, hi, lo} + 17'h00001;
            end
            // high byte is the reload value
            MODE_RELOAD: begin
                if (lo == 8'hff) stepCount = {1'b1, hi, hi};
                else stepCount = {1'b0, hi, lo + 8'h01};
            end
            // split low byte; high byte is stepped elsewhere
            default: begin
                stepCount = {(lo == 8'hff), hi, lo + 8'h01};
            end
        endcase
    endfunction : stepCount

    // pin synchronisers, two flops each
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin0Sync_q <= 2'b00;
            pin1Sync_q <= 2'b00;
        end else begin
            pin0Sync_q <= {pin0Sync_q[0], ext_irq0_pin};
            pin1Sync_q <= {pin1Sync_q[0], ext_irq1_pin};
        end
    end
    assign pin0 = pin0Sync_q[1];
    assign pin1 = pin1Sync_q[1];

    // tick generation: fcpu/12 and the two prescalers
    always_comb begin
        mode0 = tmr_mode_t'(tmode_q[1:0]);
        mode1 = tmr_mode_t'(tmode_q[5:4]);
        // stop request freezes fcpu and fosc ticks
        stopped = clkctl_q[`BIT_STOPREQ];
        cpu12 = cpuTick && (cpuDiv_q == `CPU_DIV_LAST) && !stopped;
        // fcpu/12 divider, wraps after its last count
        cpuDiv_d = cpuDiv_q;
        if (cpuTick && !stopped) begin
            cpuDiv_d = (cpuDiv_q == `CPU_DIV_LAST) ? 4'd0 : cpuDiv_q + 4'd1;
        end
        // in stop mode only the slow source keeps running, and only with stop-wake
        ext0 = presc_q[`BIT_T0SLOW] ? (slowTick && (!stopped || clkctl_q[`BIT_STOP_WAKE_ENABLE]))
                                     : (oscTick && !stopped);

        // timer 0 prescaler; a rate change keeps the running phase
        div0_d = div0_q;
        src0 = 1'b0;
        if (ext0) begin
            src0 = prescDone(div0_q, presc_q[6:4]);
            div0_d = src0 ? 7'h00 : div0_q + 7'h01;
        end

        // timer 1 prescaler runs from fosc only
        div1_d = div1_q;
        src1 = 1'b0;
        if (oscTick && !stopped) begin
            src1 = prescDone(div1_q, presc_q[2:0]);
            div1_d = src1 ? 7'h00 : div1_q + 7'h01;
        end

        // pin gating, then run bits and clock select
        gate0 = !tmode_q[`BIT_TMR0_PIN_GATE] || pin0;
        gate1 = !tmode_q[`BIT_TMR1_PIN_GATE] || pin1;
        run0 = tctrl_q[`BIT_T0RUN];
        run1 = tctrl_q[`BIT_T1RUN];
        tick0 = (tmode_q[`BIT_T0CSEL] ? src0 : cpu12) && gate0 && run0;
        tick1 = (tmode_q[`BIT_T1CSEL] ? src1 : cpu12) && gate1 && run1;
        // split high byte: fixed fcpu/12, never gated
        tickHi = cpu12 && run1;
    end

    // prescaler registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cpuDiv_q <= 4'd0;
            div0_q   <= 7'h00;
            div1_q   <= 7'h00;
        end else begin
            cpuDiv_q <= cpuDiv_d;
            div0_q   <= div0_d;
            div1_q   <= div1_d;
        end
    end

    // bus decode, counting, flags
    always_comb begin
        logic [16:0] s0;
        logic [16:0] s1;
        s0 = stepCount(mode0, t0lo_q, t0hi_q);
        s1 = stepCount(mode1, t1lo_q, t1hi_q);
        // a request is taken once; the pending ack blocks a second take
        wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i && !ack_q;
        rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;
        ack_d = wb_cyc_i && wb_stb_i && !ack_q;

        // hold every register unless written or counted
        tctrl_d = tctrl_q;
        tmode_d = tmode_q;
        presc_d = presc_q;
        ien_d = ien_q;
        clkctl_d = clkctl_q;
        t0lo_d = t0lo_q;
        t0hi_d = t0hi_q;
        t1lo_d = t1lo_q;
        t1hi_d = t1hi_q;

        // no wrap unless a tick lands on the last count
        ov0 = 1'b0;
        ov1 = 1'b0;
        ovHi = 1'b0;

        // timer 0 count
        if (mode0 == MODE_SPLIT) begin
            if (tick0) begin
                t0lo_d = s0[7:0];
                ov0 = s0[16];
            end
            if (tickHi) begin
                t0hi_d = t0hi_q + 8'h01;
                ovHi = (t0hi_q == 8'hff);
            end
        end else if (tick0) begin
            {t0hi_d, t0lo_d} = s0[15:0];
            ov0 = s0[16];
        end

        // timer 1 counts on; in split mode its wrap raises nothing
        if (mode1 != MODE_SPLIT && tick1) begin
            {t1hi_d, t1lo_d} = s1[15:0];
            ov1 = s1[16] && (mode0 != MODE_SPLIT);
        end

        // software writes, clear of flags by write or service
        if (wr) begin
            case (wb_adr_i)
                `ADR_TCTRL:   tctrl_d = wb_dat_i & `TCTRL_MASK;
                `ADR_TMODE:   tmode_d = wb_dat_i;
                `ADR_PRESC:   presc_d = wb_dat_i & `PRESC_MASK;
                `ADR_IENMAIN: ien_d = wb_dat_i;
                `ADR_CLKCTL:  clkctl_d = {6'h00, wb_dat_i[1:0]};
                `ADR_T0LO:    t0lo_d = wb_dat_i;
                `ADR_T0HI:    t0hi_d = wb_dat_i;
                `ADR_T1LO:    t1lo_d = wb_dat_i;
                `ADR_T1HI:    t1hi_d = wb_dat_i;
                default:      ;
            endcase
        end
        if (tmr0IrqAck) tctrl_d[`BIT_T0FLAG] = 1'b0;
        if (tmr1IrqAck) tctrl_d[`BIT_T1FLAG] = 1'b0;

        // set wins over any clear in the same cycle
        if (ov0) tctrl_d[`BIT_T0FLAG] = 1'b1;
        if (ov1 || ovHi) tctrl_d[`BIT_T1FLAG] = 1'b1;

        // wake ends stop mode
        if (stopWakeReq) clkctl_d[`BIT_STOPREQ] = 1'b0;

        // read data registered, stands until the next read
        rdat_d = rdat_q;
        if (rd) begin
            case (wb_adr_i)
                `ADR_TCTRL:   rdat_d = tctrl_q;
                `ADR_TMODE:   rdat_d = tmode_q;
                `ADR_PRESC:   rdat_d = presc_q;
                `ADR_IENMAIN: rdat_d = ien_q;
                `ADR_CLKCTL:  rdat_d = clkctl_q;
                `ADR_STATUS:  rdat_d = {5'h00, stopped, pin1, pin0};
                `ADR_T0LO:    rdat_d = t0lo_q;
                `ADR_T0HI:    rdat_d = t0hi_q;
                `ADR_T1LO:    rdat_d = t1lo_q;
                `ADR_T1HI:    rdat_d = t1hi_q;
                default:      rdat_d = 8'h00;
            endcase
        end
    end

    // register state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tctrl_q  <= `RST_BYTE;
            tmode_q  <= `RST_BYTE;
            presc_q  <= `RST_BYTE;
            ien_q    <= `RST_BYTE;
            clkctl_q <= `RST_BYTE;
            t0lo_q   <= `RST_BYTE;
            t0hi_q   <= `RST_BYTE;
            t1lo_q   <= `RST_BYTE;
            t1hi_q   <= `RST_BYTE;
            rdat_q   <= `RST_BYTE;
            ack_q    <= 1'b0;
        end else begin
            tctrl_q  <= tctrl_d;
            tmode_q  <= tmode_d;
            presc_q  <= presc_d;
            ien_q    <= ien_d;
            clkctl_q <= clkctl_d;
            t0lo_q   <= t0lo_d;
            t0hi_q   <= t0hi_d;
            t1lo_q   <= t1lo_d;
            t1hi_q   <= t1hi_d;
            rdat_q   <= rdat_d;
            ack_q    <= ack_d;
        end
    end

    // interrupt requests: flag gated by its enable and the global enable
    assign tmr0IrqReq  = tctrl_q[`BIT_T0FLAG] && ien_q[`BIT_T0IE] && ien_q[`BIT_GIE];
    assign tmr1IrqReq  = tctrl_q[`BIT_T1FLAG] && ien_q[`BIT_T1IE] && ien_q[`BIT_GIE];
    // wake needs stop, stop-wake and a live timer 0 request; lasts one cycle
    assign stopWakeReq = stopped && clkctl_q[`BIT_STOP_WAKE_ENABLE] && tmr0IrqReq;
    assign stopMode    = stopped;
    // bus outputs straight from flops
    assign wb_dat_o    = rdat_q;
    assign wb_ack_o    = ack_q;
endmodule : dual_up_timer_counter
